/* File: design/bsl_pkg.sv */
// Package for the snoop, backoff and atomic-sequence bus block.
// Assumes a single bus clock; all pins are sampled synchronously.
package bsl_pkg;

   // ---------------------------------------------------------------
   // Widths and timing counts
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned LINE_LSB = 5;
   localparam int unsigned DRV_LSB = 3;
   localparam int unsigned ATOM_GAP_CLKS = 1;
   localparam int unsigned FLOAT_MIN_CLKS = 2;
   localparam int unsigned ATOM_MIN_CYC = 2;
   localparam int unsigned ATOM_MAX_CYC = 5;
   localparam logic [2:0] BEATS_RST = 3'h0;
   localparam logic [2:0] WB_LAST_BEAT = 3'h3;

   // ---------------------------------------------------------------
   // Line states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BSL_INVALID = 2'h0,
      BSL_SHR = 2'h1,
      BSL_EXC = 2'h2,
      BSL_MOD = 2'h3
   } bsl_line_t;

   // Bus controller states, one-hot
   typedef enum logic [4:0] {
      BSL_IDLE  = 5'h01,
      BSL_XFER  = 5'h02,
      BSL_WBACK = 5'h04,
      BSL_HOLD  = 5'h08,
      BSL_GAP   = 5'h10
   } bsl_state_t;

   // A cycle request from the core side
   typedef struct packed {
      logic [ADDR_W-1:DRV_LSB] addr;
      logic write;
      logic atomic;
      logic last;
      logic split;
      logic [2:0] beats;
   } bsl_req_t;

   // Result of the tag lookup for a snoop
   typedef struct packed {
      logic hit;
      bsl_line_t state;
   } bsl_look_t;

endpackage

/* File: design/bsl_bus_ctrl.sv */
// Bus logic for snoops, backoff abort/restart and atomic sequences.
// Assumes the core presents requests and a tag lookup result combinationally
// for the snoop address; all pins are synchronous to clk_sys_in.
// Operation
// - Clean hit: match high, dirty low, the edge after snoop valid.
// - Match holds its level until the next snoop.
// - Kill sampled: line goes invalid, else shared; nothing shown on bus.
// - Modified line is written back before its state changes.
// - Float request sampled each clock; cycle start may follow its release.
// - Dirty hit: match and dirty together, writeback before new cycles.
// - Float held through writeback: address stays undriven.
// - Float released first: writeback driven from captured line address.
// - Abort request aborts all cycles at once, even with ready.
// - Aborted cycle restarts after release; other side keeps cacheable.
// - Dirty hit under abort: writeback first, then the restart.
// - Atomic flag spans atomic sequences of two to five cycles.
// - Operands flushed before atomics; atomic reads never allocate.
// - Atomic flag low at least one clock between sequences.
// - Misaligned atomic transfer raises split flag, extra cycles.
// - Atomic flag rises with first strobe, falls on last ready.
// - Float request floats address and parity; data, control stay.
// - During abort address and control float; snoop match, dirty and parity error stay driven.
// - Other side qualifies the snoop line address with snoop valid.
// - Snoop address parity error pulses the error one clock.
module bsl_bus_ctrl (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Bus control inputs
   input wire logic addr_float_req_in,
   input wire logic snoop_addr_valid_in,
   input wire logic snoop_kill_in,
   input wire logic xfer_ready_in,
   input wire logic abort_release_req_in,
   input wire logic cacheable_in,
   input wire logic [bsl_pkg::ADDR_W-1:bsl_pkg::DRV_LSB] addr_in,
   input wire logic addr_par_in,
   // Core side
   input wire logic req_valid_in,
   input wire bsl_pkg::bsl_req_t req_in,
   input wire bsl_pkg::bsl_look_t look_in,
   output logic req_ready_out,
   output logic line_update_out,
   output bsl_pkg::bsl_line_t line_state_out,
   output logic [bsl_pkg::ADDR_W-1:bsl_pkg::LINE_LSB] line_addr_out,
   output logic allocate_out,
   // Bus outputs
   output logic [bsl_pkg::ADDR_W-1:bsl_pkg::DRV_LSB] addr_out,
   output logic addr_oe_out,
   output logic addr_par_out,
   output logic ctrl_oe_out,
   output logic cycle_start_strobe_out,
   output logic write_out,
   output logic atomic_seq_out,
   output logic split_cycle_flag_out,
   output logic snoop_match_out,
   output logic snoop_match_dirty_out,
   output logic addr_par_error_out
);

   bsl_pkg::bsl_state_t state_q;
   bsl_pkg::bsl_req_t cur_q;
   logic [2:0] beat_q;
   logic snoop_pend_q;
   logic wb_pend_q;
   bsl_pkg::bsl_line_t wb_next_q;
   logic [bsl_pkg::ADDR_W-1:bsl_pkg::LINE_LSB] snoop_addr_q;
   logic [1:0] float_cnt_q;
   logic aborted_q;
   logic cacheable_q;
   logic snoop_ok;
   logic start;
   logic done;

   // ---------------------------------------------------------------
   // Snoop recognition
   // ---------------------------------------------------------------
   // A float-opened snoop counts only after two sampled clocks of request
   assign snoop_ok = snoop_addr_valid_in &&
                     (abort_release_req_in || float_cnt_q == 2'(bsl_pkg::FLOAT_MIN_CLKS));
   assign done = state_q == bsl_pkg::BSL_XFER && xfer_ready_in && !abort_release_req_in &&
                 beat_q == cur_q.beats;
   // New cycles wait for float release, abort release and any writeback
   assign start = state_q == bsl_pkg::BSL_IDLE && !addr_float_req_in &&
                  !abort_release_req_in && !wb_pend_q && !snoop_pend_q &&
                  (aborted_q || req_valid_in);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         float_cnt_q <= 2'h0;
      end else if (!addr_float_req_in) begin
         float_cnt_q <= 2'h0;
      end else if (float_cnt_q != 2'(bsl_pkg::FLOAT_MIN_CLKS)) begin
         float_cnt_q <= float_cnt_q + 2'h1;
      end
   end

   // Match outputs; match only changes at a snoop
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         snoop_match_out <= 1'b0;
         snoop_match_dirty_out <= 1'b0;
         addr_par_error_out <= 1'b0;
      end else begin
         addr_par_error_out <= snoop_ok && (^addr_in != addr_par_in);
         if (snoop_ok) begin
            snoop_match_out <= look_in.hit;
            snoop_match_dirty_out <= look_in.hit && look_in.state == bsl_pkg::BSL_MOD;
         end else if (state_q == bsl_pkg::BSL_WBACK && xfer_ready_in &&
                      !abort_release_req_in && beat_q == bsl_pkg::WB_LAST_BEAT) begin
            snoop_match_dirty_out <= 1'b0;
         end
      end
   end

   // Snoop capture and line state change
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         snoop_pend_q <= 1'b0;
         wb_pend_q <= 1'b0;
         wb_next_q <= bsl_pkg::BSL_INVALID;
         snoop_addr_q <= '0;
         line_update_out <= 1'b0;
         line_state_out <= bsl_pkg::BSL_INVALID;
         line_addr_out <= '0;
      end else begin
         line_update_out <= 1'b0;
         snoop_pend_q <= 1'b0;
         if (snoop_ok && look_in.hit) begin
            snoop_addr_q <= addr_in[bsl_pkg::ADDR_W-1:bsl_pkg::LINE_LSB];
            wb_next_q <= snoop_kill_in ? bsl_pkg::BSL_INVALID : bsl_pkg::BSL_SHR;
            if (look_in.state == bsl_pkg::BSL_MOD) begin
               wb_pend_q <= 1'b1;
               snoop_pend_q <= 1'b1;
            end else begin
               line_update_out <= 1'b1;
               line_addr_out <= addr_in[bsl_pkg::ADDR_W-1:bsl_pkg::LINE_LSB];
               line_state_out <= snoop_kill_in ? bsl_pkg::BSL_INVALID : bsl_pkg::BSL_SHR;
            end
         end else if (state_q == bsl_pkg::BSL_WBACK && xfer_ready_in &&
                      !abort_release_req_in && beat_q == bsl_pkg::WB_LAST_BEAT) begin
            wb_pend_q <= 1'b0;
            line_update_out <= 1'b1;
            line_addr_out <= snoop_addr_q;
            line_state_out <= wb_next_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_q <= bsl_pkg::BSL_IDLE;
         cur_q <= '0;
         beat_q <= bsl_pkg::BEATS_RST;
         aborted_q <= 1'b0;
         cacheable_q <= 1'b0;
      end else if (abort_release_req_in) begin
         // Abort wins over a same-edge ready; attributes stay frozen
         if (state_q == bsl_pkg::BSL_XFER) begin
            aborted_q <= 1'b1;
         end
         state_q <= bsl_pkg::BSL_HOLD;
         beat_q <= bsl_pkg::BEATS_RST;
      end else begin
         unique case (state_q)
            bsl_pkg::BSL_HOLD: state_q <= bsl_pkg::BSL_IDLE;
            bsl_pkg::BSL_IDLE: begin
               if (wb_pend_q && !snoop_pend_q) begin
                  state_q <= bsl_pkg::BSL_WBACK;
               end else if (start) begin
                  if (!aborted_q) begin
                     cur_q <= req_in;
                  end
                  state_q <= bsl_pkg::BSL_XFER;
               end
            end
            bsl_pkg::BSL_XFER: begin
               if (xfer_ready_in) begin
                  beat_q <= beat_q + 3'h1;
               end
               if (done) begin
                  beat_q <= bsl_pkg::BEATS_RST;
                  aborted_q <= 1'b0;
                  cacheable_q <= cacheable_in;
                  // Gap after the last cycle of an atomic sequence
                  state_q <= (cur_q.atomic && cur_q.last) ? bsl_pkg::BSL_GAP
                                                           : bsl_pkg::BSL_IDLE;
               end
            end
            bsl_pkg::BSL_WBACK: begin
               if (xfer_ready_in) begin
                  beat_q <= beat_q + 3'h1;
               end
               if (xfer_ready_in && beat_q == bsl_pkg::WB_LAST_BEAT) begin
                  beat_q <= bsl_pkg::BEATS_RST;
                  state_q <= bsl_pkg::BSL_IDLE;
               end
            end
            bsl_pkg::BSL_GAP: state_q <= bsl_pkg::BSL_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bus outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cycle_start_strobe_out <= 1'b0;
         write_out <= 1'b0;
         addr_out <= '0;
         addr_par_out <= 1'b0;
         req_ready_out <= 1'b0;
         allocate_out <= 1'b0;
         split_cycle_flag_out <= 1'b0;
      end else begin
         cycle_start_strobe_out <= 1'b0;
         req_ready_out <= 1'b0;
         if (!abort_release_req_in && state_q == bsl_pkg::BSL_IDLE) begin
            if (wb_pend_q && !snoop_pend_q) begin
               cycle_start_strobe_out <= 1'b1;
               write_out <= 1'b1;
               addr_out <= {snoop_addr_q, 2'h0};
               addr_par_out <= ^snoop_addr_q;
            end else if (start) begin
               cycle_start_strobe_out <= 1'b1;
               req_ready_out <= !aborted_q;
               write_out <= aborted_q ? cur_q.write : req_in.write;
               addr_out <= aborted_q ? cur_q.addr : req_in.addr;
               addr_par_out <= aborted_q ? ^cur_q.addr : ^req_in.addr;
               split_cycle_flag_out <= aborted_q ? cur_q.split : req_in.split;
               allocate_out <= !(aborted_q ? cur_q.atomic : req_in.atomic);
            end
         end
      end
   end

   // Output enables: address floats for the float request, all for abort
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         addr_oe_out <= 1'b0;
         ctrl_oe_out <= 1'b0;
      end else begin
         ctrl_oe_out <= !abort_release_req_in;
         addr_oe_out <= !abort_release_req_in && !addr_float_req_in;
      end
   end

   // Atomic flag: rises with the first strobe, drops on the final ready
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         atomic_seq_out <= 1'b0;
      end else if (done && cur_q.atomic && cur_q.last) begin
         atomic_seq_out <= 1'b0;
      end else if (start && (aborted_q ? cur_q.atomic : req_in.atomic)) begin
         atomic_seq_out <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_clean_hit_match: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      snoop_ok && look_in.hit && look_in.state != bsl_pkg::BSL_MOD |=>
      snoop_match_out && !snoop_match_dirty_out)
      else $error("clean hit response wrong");
   a_match_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !snoop_ok |=> $stable(snoop_match_out))
      else $error("match changed without snoop");
   a_dirty_hit_pair: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      snoop_ok && look_in.hit && look_in.state == bsl_pkg::BSL_MOD |=>
      snoop_match_out && snoop_match_dirty_out)
      else $error("dirty hit response wrong");
   a_abort_no_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      abort_release_req_in |=> !cycle_start_strobe_out && !ctrl_oe_out)
      else $error("cycle started under abort");
   a_float_addr_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      addr_float_req_in |=> !addr_oe_out)
      else $error("address driven during float");
   a_atomic_gap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(atomic_seq_out) |=> !atomic_seq_out)
      else $error("atomic gap too short");
   a_parity_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      addr_par_error_out && !snoop_ok |=> !addr_par_error_out)
      else $error("parity error too long");
   a_wb_first: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      wb_pend_q && state_q == bsl_pkg::BSL_IDLE |=> !(req_ready_out))
      else $error("new cycle before writeback");
   a_atomic_with_strobe: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(atomic_seq_out) |-> cycle_start_strobe_out)
      else $error("atomic flag rose without strobe");

endmodule

/* File: bench/bsl_sys_model.sv */
// Far-side model: answers each bus cycle with ready beats.
// Assumes the bench sets the beat count before each cycle starts.
module bsl_sys_model (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Bus side
   input wire logic cycle_start_strobe_in,
   input wire logic abort_release_req_in,
   input wire logic [2:0] beats_in,
   input wire logic slow_in,
   output logic xfer_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act_q;
   logic [2:0] cnt_q;
   always_ff @(posedge clk_sys_in) begin
      // A strobe floated under abort never opens a cycle here
      if (!rst_n_in || abort_release_req_in) begin
         act_q <= 1'b0;
         xfer_ready_out <= 1'b0;
      end else if (cycle_start_strobe_in) begin
         act_q <= 1'b1;
         cnt_q <= 3'h0;
         xfer_ready_out <= 1'b0;
      end else if (act_q) begin
         if (xfer_ready_out) begin
            cnt_q <= cnt_q + 3'h1;
         end
         if (xfer_ready_out && cnt_q == beats_in) begin
            act_q <= 1'b0;
            xfer_ready_out <= 1'b0;
         end else begin
            // Slow mode inserts a wait state between beats, none before the first
            xfer_ready_out <= slow_in ? ~xfer_ready_out : 1'b1;
         end
      end
   end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the snoop, backoff and atomic bus block.
// Assumes the far-side model paces every cycle with ready beats.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals and helpers
   // ------------------------------------------------------------
   localparam logic [31:3] A1 = 29'h0123_4561;
   localparam logic [31:3] A2 = 29'h0abc_de7;
   localparam logic [31:3] A3 = 29'h1555_0002;
   logic clk, rst_n, afr, sav, kill, rdy, abrt, cach, par, rv, upd, alloc, rrdy;
   logic aoe, apo, coe, stb, wr, atom, split, mt, md, perr, pslow;
   logic [31:3] ain, aout;
   logic [31:5] laddr;
   logic [2:0] pbeats;
   bsl_pkg::bsl_req_t req;
   bsl_pkg::bsl_look_t look;
   bsl_pkg::bsl_line_t lst;
   int fails, compares, gap;
   bsl_bus_ctrl bsl_bus_ctrl_inst (.clk_sys_in(clk), .rst_n_in(rst_n),
      .addr_float_req_in(afr), .snoop_addr_valid_in(sav), .snoop_kill_in(kill),
      .xfer_ready_in(rdy), .abort_release_req_in(abrt), .cacheable_in(cach),
      .addr_in(ain), .addr_par_in(par), .req_valid_in(rv), .req_in(req), .look_in(look),
      .req_ready_out(rrdy), .line_update_out(upd), .line_state_out(lst),
      .line_addr_out(laddr), .allocate_out(alloc), .addr_out(aout), .addr_oe_out(aoe),
      .addr_par_out(apo), .ctrl_oe_out(coe), .cycle_start_strobe_out(stb),
      .write_out(wr), .atomic_seq_out(atom), .split_cycle_flag_out(split),
      .snoop_match_out(mt), .snoop_match_dirty_out(md), .addr_par_error_out(perr));
   bsl_sys_model bsl_sys_model_inst (.clk_sys_in(clk), .rst_n_in(rst_n),
      .cycle_start_strobe_in(stb), .abort_release_req_in(abrt), .beats_in(pbeats),
      .slow_in(pslow), .xfer_ready_out(rdy));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(negedge clk) begin
      if (atom === 1'b0) gap++;
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic sv(input int s);
      case (s)
         0: return stb;
         1: return upd;
         2: return ~atom;
         3: return perr;
         default: return mt;
      endcase
   endfunction
   // Bounded wait for a strobe, pulse or level at a settled point
   task wt(input int s);
      int n;
      n = 0;
      while (n < 60 && sv(s) !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      chk("wait", n < 60, 1);
   endtask
   task snoop(input logic [31:3] a, input logic bad, input logic k, input logic rel);
      @(posedge clk);
      afr <= 1'b1;
      ain <= a;
      par <= ^a ^ bad;
      repeat (2) @(posedge clk);
      sav <= 1'b1;
      kill <= k;
      @(posedge clk);
      sav <= 1'b0;
      kill <= 1'b0;
      afr <= afr & ~rel;
      @(negedge clk);
   endtask
   task acyc(input logic [31:3] a, input logic l, input logic s);
      @(posedge clk);
      req <= '{addr: a, write: l, atomic: 1'b1, last: l, split: s, beats: 3'h0};
      rv <= 1'b1;
      @(negedge clk);
      wt(0);
      chk("atomic", atom, 1);
      chk("alloc", alloc, 0);
      chk("split", split, s);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_clean;
      look <= '{hit: 1'b1, state: bsl_pkg::BSL_EXC};
      snoop(A1, 1'b0, 1'b1, 1'b0);
      wt(4);
      chk("dirty", md, 0);
      chk("addr_oe", aoe, 0);
      wt(1);
      chk("state", lst, bsl_pkg::BSL_INVALID);
      @(posedge clk);
      afr <= 1'b0;
      repeat (3) @(negedge clk);
      chk("match", mt, 1);
      chk("addr_oe", aoe, 1);
      $display("clean hit test done");
   endtask
   task t_dirty;
      look <= '{hit: 1'b1, state: bsl_pkg::BSL_MOD};
      pbeats <= 3'h3;
      snoop(A2, 1'b0, 1'b0, 1'b1);
      wt(0);
      chk("dirty", md, 1);
      chk("match", mt, 1);
      chk("wb_addr", aout, {A2[31:5], 2'h0});
      chk("state", upd, 0);
      wt(1);
      chk("state", lst, bsl_pkg::BSL_SHR);
      look <= '0;
      repeat (2) @(negedge clk);
      chk("dirty", md, 0);
      $display("dirty hit test done");
   endtask
   task t_atomic;
      pbeats <= 3'h0;
      acyc(A1, 1'b0, 1'b0);
      acyc(A3, 1'b1, 1'b1);
      gap = 0;
      acyc(A1, 1'b0, 1'b0);
      chk("gap", gap > 0, 1);
      acyc(A3, 1'b1, 1'b0);
      @(posedge clk);
      rv <= 1'b0;
      wt(2);
      $display("atomic test done");
   endtask
   task t_abort;
      int n;
      pslow <= 1'b1;
      pbeats <= 3'h0;
      @(posedge clk);
      req <= '{addr: A3, write: 1'b0, atomic: 1'b0, last: 1'b0, split: 1'b0, beats: 3'h0};
      rv <= 1'b1;
      @(negedge clk);
      wt(0);
      @(posedge clk);
      rv <= 1'b0;
      // Abort lands on the final ready edge, so that ready must not finish the cycle
      @(posedge clk);
      abrt <= 1'b1;
      pbeats <= 3'h3;
      ain <= A1;
      par <= ^A1;
      look <= '{hit: 1'b1, state: bsl_pkg::BSL_MOD};
      @(posedge clk);
      sav <= 1'b1;
      @(posedge clk);
      sav <= 1'b0;
      for (n = 0; n < 6; n++) begin
         @(negedge clk);
         chk("strobe", stb, 0);
      end
      chk("ctrl_oe", coe, 0);
      chk("dirty", md, 1);
      @(posedge clk);
      abrt <= 1'b0;
      look <= '0;
      @(negedge clk);
      wt(0);
      chk("wb_addr", aout, {A1[31:5], 2'h0});
      wt(1);
      chk("state", lst, bsl_pkg::BSL_SHR);
      @(posedge clk);
      pbeats <= 3'h0;
      @(negedge clk);
      wt(0);
      chk("restart", aout, A3);
      repeat (12) @(negedge clk);
      pslow <= 1'b0;
      $display("abort test done");
   endtask
   task t_parity;
      @(posedge clk);
      look <= '{hit: 1'b1, state: bsl_pkg::BSL_MOD};
      pbeats <= 3'h3;
      // Float stays up through the writeback, so the address must stay off
      snoop(A3, 1'b1, 1'b1, 1'b0);
      wt(3);
      @(negedge clk);
      chk("par_err", perr, 0);
      wt(0);
      chk("addr_oe", aoe, 0);
      wt(1);
      chk("state", lst, bsl_pkg::BSL_INVALID);
      @(posedge clk);
      afr <= 1'b0;
      look <= '0;
      $display("parity test done");
   endtask
   task finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      {rst_n, afr, sav, kill, abrt, rv, par, pslow} = '0;
      cach = 1'b1;
      {pbeats, ain, req, look, fails, compares, gap} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      t_clean();
      t_dirty();
      t_atomic();
      t_abort();
      t_parity();
      finish_test();
   end
   // Whole run needs well under two thousand cycles
   initial begin
      #50us;
      fails++;
      finish_test();
   end
endmodule
